// ---- logic/bcl_loader.sv ----
// Bootstrap configuration loader: window, source select and validation.
// Notes on behaviour
// RULE_01 - Window five pages; OTP four; EEPROM three.
// RULE_02 - Pages 0,1 hold ID and calibration, read-only.
// RULE_03 - Pages 0,1 refreshed from OTP every power-on.
// RULE_04 - Page 4 loaded only from EEPROM, development start.
// RULE_05 - Clock pin level picks development mode, source.
// RULE_06 - Zero customer identifier keeps device off.
// RULE_07 - Development: absent EEPROM or bad signature, off.
// RULE_08 - Reload bit selects reloading pages 2-4.
// RULE_09 - Checks still run when reloading is disabled.
// RULE_10 - Reload bit resets set, writable after unlock.
// RULE_11 - Serial master reads EEPROM with address A1h.
// RULE_12 - EEPROM bytes pack big-endian into window words.
// RULE_13 - EEPROM seen as six byte pages.
// RULE_14 - EEPROM is read only, never written.
// RULE_15 - Window reachable by control port; memories copied.
// RULE_16 - Pages 2,3 copy to OTP only programming.
// RULE_17 - External EEPROM programming only while device off.
// RULE_18 - Active-high on/off GPIO needs OTP polarity set; the code applies this gate in development mode only.
// RULE_19 - Load and validate first; NACK aborts start.
`timescale 1ns/100ps
module bcl_loader #(
  parameter int QUARTER = 20
) (
  // Clock, reset and enable
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire logic i_link_clock,
  // Control interface
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [15:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  output logic [15:0] o_reg_rdata,
  output logic o_reg_rvalid,
  // Power state machine
  input wire logic i_on_sched,
  input wire logic i_program_state,
  input wire logic i_otp_copy_req,
  output logic o_busy,
  output logic o_start_ok,
  output logic o_stay_off,
  output logic o_dev_mode,
  // One-time memory
  output logic [4:0] o_otp_addr,
  output logic o_otp_rd,
  output logic o_otp_wr,
  output logic [15:0] o_otp_wdata,
  input wire logic [15:0] i_otp_rdata,
  // Serial pins
  input wire logic i_scl,
  output logic o_scl,
  output logic o_scl_oe,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe,
  // GPIO polarity in force
  output logic [bcl_pkg::NUM_GPIO-1:0] o_gpio_pol_eff
);
  import bcl_pkg::*;

  bcl_link_if lnk ();

  bcl_state_t state, next_state;
  logic [15:0] win [WIN_DEPTH];
  logic [15:0] next_win [WIN_DEPTH];
  logic [5:0] addr, next_addr;
  logic [4:0] otp_addr, next_otp_addr;
  logic otp_rd, next_otp_rd, otp_wr, next_otp_wr;
  logic [15:0] otp_wdata, next_otp_wdata;
  logic dev, next_dev, reload, next_reload;
  logic unlocked, next_unlocked, ee_fail, next_ee_fail;
  logic [15:0] rdata, next_rdata;
  logic rvalid, next_rvalid, start_ok, next_start_ok;
  logic stay_off, next_stay_off, busy, next_busy;
  logic start_tgl, next_start_tgl, word_seen, next_word_seen;
  logic done_seen, next_done_seen;
  logic [NUM_GPIO-1:0] otp_pol, next_otp_pol, gpol, next_gpol;
  logic word_s, done_s, scl_s, link_rst, cfg_ok;
  logic [5:0] widx;

  // ***********************************************************
  // Address decode
  // ***********************************************************
  function automatic logic win_hit(input logic [15:0] a);
    return (a >= WIN_BASE) && (a < WIN_END);
  endfunction

  function automatic logic [5:0] win_idx(input logic [15:0] a);
    logic [15:0] d;
    d = a - WIN_BASE;
    return d[5:0];
  endfunction

  // ***********************************************************
  // Crossings and serial engine
  // ***********************************************************
  bcl_sync #(.W(3)) u_sys_sync (
    .i_clock(i_clock),
    .i_async({lnk.word_tgl, lnk.done_tgl, i_scl}),
    .o_sync({word_s, done_s, scl_s})
  );

  bcl_sync #(.W(1)) u_rst_sync (
    .i_clock(i_link_clock),
    .i_async(i_sys_rst),
    .o_sync(link_rst)
  );

  bcl_ee_reader #(.QUARTER(QUARTER)) u_reader (
    .i_link_clock(i_link_clock),
    .i_link_rst(link_rst),
    .lnk(lnk.eng),
    .i_sda(i_sda),
    .o_scl_oe(o_scl_oe),
    .o_sda_oe(o_sda_oe)
  );

  assign lnk.start_tgl = start_tgl;

  // ***********************************************************
  // Loader and register port
  // ***********************************************************
  always_comb begin
    next_state = state; next_win = win; next_addr = addr;
    next_otp_addr = otp_addr; next_otp_rd = otp_rd;
    next_otp_wr = 1'b0; next_otp_wdata = otp_wdata;
    next_dev = dev; next_reload = reload; next_unlocked = unlocked;
    next_ee_fail = ee_fail; next_rdata = rdata; next_rvalid = 1'b0;
    next_start_ok = 1'b0; next_stay_off = 1'b0;
    next_start_tgl = start_tgl; next_word_seen = word_seen;
    next_done_seen = done_seen; next_otp_pol = otp_pol;
    widx = win_idx(i_reg_addr);
    // Pass (set) wins only if every check below holds.
    cfg_ok = (win[CUST_IDX] != 16'h0000) // RULE_06 RULE_09
             && (!dev || (!ee_fail && win[SIG_IDX] == SIG_VALUE)); // RULE_07
    if (i_reg_rd) begin
      next_rvalid = 1'b1;
      next_rdata = 16'h0000;
      if (win_hit(i_reg_addr)) next_rdata = win[widx]; // RULE_15
      else if (i_reg_addr == RELOAD_ADDR) next_rdata[RELOAD_BIT] = reload;
    end
    // Writes are held off while a load or copy runs.
    if (i_reg_wr && state == ST_IDLE) begin
      if (win_hit(i_reg_addr) && widx >= BOOT_FIRST) // RULE_02 RULE_15
        next_win[widx] = i_reg_wdata;
      else if (i_reg_addr == SEC_ADDR)
        next_unlocked = (i_reg_wdata == USER_KEY); // RULE_10
      else if (i_reg_addr == RELOAD_ADDR && unlocked)
        next_reload = i_reg_wdata[RELOAD_BIT]; // RULE_10
    end
    unique case (state)
      ST_IDLE: begin
        if (i_on_sched) begin
          next_dev = scl_s; // RULE_05
          next_addr = 6'h00;
          next_otp_rd = 1'b0;
          next_ee_fail = 1'b0;
          next_state = ST_OTP; // RULE_03
        end else if (i_otp_copy_req && i_program_state) begin
          next_addr = BOOT_FIRST;
          next_state = ST_PROG; // RULE_16
        end
      end
      ST_OTP: begin
        // All four OTP pages are read so that the OTP polarity bits
        // are known even when the boot pages come from the EEPROM.
        if (otp_rd) begin
          next_otp_rd = 1'b0;
          next_addr = addr + 6'h01;
          if (addr <= FIX_LAST || (reload && !dev)) // RULE_03 RULE_08
            next_win[addr] = i_otp_rdata; // RULE_01
          for (int n = 0; n < NUM_GPIO; n++) begin
            if (addr == GPIO_IDX + 6'(n))
              next_otp_pol[n] = i_otp_rdata[GPIO_POL_BIT]; // RULE_18
          end
          if (addr == OTP_LAST) begin
            next_addr = BOOT_FIRST;
            if (reload && dev) begin // RULE_05 RULE_08
              next_start_tgl = !start_tgl;
              next_state = ST_EE;
            end else begin
              next_state = ST_CHECK; // RULE_09
            end
          end
        end else begin
          next_otp_rd = 1'b1;
          next_otp_addr = addr[4:0];
        end
      end
      ST_EE: begin
        if (word_s != word_seen) begin
          next_word_seen = word_s;
          if (addr < EE_END) begin
            next_win[addr] = lnk.word; // RULE_01 RULE_04 RULE_12
            next_addr = addr + 6'h01;
          end
        end else if (done_s != done_seen) begin
          next_done_seen = done_s;
          next_ee_fail = lnk.nack || (addr != EE_END); // RULE_07 RULE_19
          next_state = ST_CHECK;
        end
      end
      ST_CHECK: begin
        next_start_ok = cfg_ok; // RULE_19
        next_stay_off = !cfg_ok; // RULE_06 RULE_07
        next_state = ST_IDLE;
      end
      ST_PROG: begin
        next_otp_wr = 1'b1; // RULE_16
        next_otp_addr = addr[4:0];
        next_otp_wdata = win[addr];
        next_addr = addr + 6'h01;
        if (addr == OTP_LAST) next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
    next_busy = (next_state != ST_IDLE);
    for (int n = 0; n < NUM_GPIO; n++) begin
      next_gpol[n] = win[GPIO_IDX + 6'(n)][GPIO_POL_BIT];
      if (dev && win[GPIO_IDX + 6'(n)][7:0] == GPIO_FN_ONOFF)
        next_gpol[n] = next_gpol[n] && otp_pol[n]; // RULE_18
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      state <= ST_IDLE;
      for (int i = 0; i < WIN_DEPTH; i++) win[i] <= 16'h0000;
      addr <= 6'h00; otp_addr <= 5'h00; otp_rd <= 1'b0; otp_wr <= 1'b0;
      otp_wdata <= 16'h0000; dev <= 1'b0; reload <= RELOAD_RST;
      unlocked <= 1'b0; ee_fail <= 1'b0; rdata <= 16'h0000;
      rvalid <= 1'b0; start_ok <= 1'b0; stay_off <= 1'b0; busy <= 1'b0;
      start_tgl <= 1'b0; word_seen <= 1'b0; done_seen <= 1'b0;
      otp_pol <= '0; gpol <= '0;
    end else if (i_clk_en) begin
      state <= next_state;
      win <= next_win;
      addr <= next_addr; otp_addr <= next_otp_addr;
      otp_rd <= next_otp_rd; otp_wr <= next_otp_wr;
      otp_wdata <= next_otp_wdata; dev <= next_dev;
      reload <= next_reload; unlocked <= next_unlocked;
      ee_fail <= next_ee_fail; rdata <= next_rdata; rvalid <= next_rvalid;
      start_ok <= next_start_ok; stay_off <= next_stay_off;
      busy <= next_busy; start_tgl <= next_start_tgl;
      word_seen <= next_word_seen; done_seen <= next_done_seen;
      otp_pol <= next_otp_pol; gpol <= next_gpol;
    end
  end

  // Open-drain pins only ever pull low.
  assign o_scl = 1'b0;
  assign o_sda = 1'b0;
  assign o_reg_rdata = rdata;
  assign o_reg_rvalid = rvalid;
  assign o_busy = busy;
  assign o_start_ok = start_ok;
  assign o_stay_off = stay_off;
  assign o_dev_mode = dev;
  assign o_otp_addr = otp_addr;
  assign o_otp_rd = otp_rd;
  assign o_otp_wr = otp_wr;
  assign o_otp_wdata = otp_wdata;
  assign o_gpio_pol_eff = gpol;

  // ***********************************************************
  // Checks
  // ***********************************************************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);

  sequence s_sched;
    state == ST_IDLE && i_on_sched && i_clk_en;
  endsequence
  sequence s_check(logic bad);
    state == ST_CHECK && i_clk_en && bad;
  endsequence

  load_begin_a: assert property (s_sched // RULE_03
    |=> state == ST_OTP && o_busy)
    else $error("scheduled start did not begin an OTP load");
  fixed_page_a: assert property (i_reg_wr && i_reg_addr == WIN_BASE // RULE_02
    && i_clk_en |=> $stable(win[0]))
    else $error("page 0 changed by a register write");
  zero_id_a: assert property (s_check(win[CUST_IDX] == 16'h0000) // RULE_06
    |=> o_stay_off && !o_start_ok)
    else $error("zero identifier did not keep the device off");
  bad_sig_a: assert property (s_check(dev // RULE_07
    && win[SIG_IDX] != SIG_VALUE)
    |=> o_stay_off && !o_start_ok)
    else $error("bad signature did not keep the device off");
  key_lock_a: assert property (i_reg_wr && i_reg_addr == RELOAD_ADDR // RULE_10
    && !unlocked |=> $stable(reload))
    else $error("reload bit changed while locked");
  otp_page4_a: assert property (state == ST_OTP // RULE_04
    |=> $stable(win[SIG_IDX]))
    else $error("page 4 changed during the OTP load");
  no_reload_a: assert property (state == ST_OTP && !reload // RULE_08
    |=> $stable(win[CUST_IDX]))
    else $error("boot page reloaded with reloading disabled");
  prog_only_a: assert property (state == ST_IDLE && !i_program_state // RULE_16
    |=> state != ST_PROG)
    else $error("OTP copy started outside programming state");
  otp_pace_a: assert property (o_otp_rd && i_clk_en |=> !o_otp_rd) // RULE_19
    else $error("OTP read strobe held for two cycles");
endmodule // bcl_loader

// ---- logic/bcl_pkg.sv ----
// Constants and types shared by the bootstrap configuration loader.
package bcl_pkg;
  // ***********************************************************
  // Window layout (words of 16 bits, eight words to a page)
  // ***********************************************************
  localparam int WIN_DEPTH = 40;
  localparam int NUM_GPIO = 6;
  localparam logic [5:0] FIX_LAST = 6'h0f;
  localparam logic [5:0] BOOT_FIRST = 6'h10;
  localparam logic [5:0] OTP_LAST = 6'h1f;
  localparam logic [5:0] SIG_IDX = 6'h20;
  localparam logic [5:0] EE_END = 6'h28;
  localparam logic [5:0] CUST_IDX = 6'h10;
  localparam logic [5:0] GPIO_IDX = 6'h18;
  localparam int GPIO_POL_BIT = 8;
  localparam logic [7:0] GPIO_FN_ONOFF = 8'h02;
  localparam logic [15:0] SIG_VALUE = 16'ha596;
  // ***********************************************************
  // Control interface map
  // ***********************************************************
  localparam logic [15:0] RELOAD_ADDR = 16'h4006;
  localparam int RELOAD_BIT = 15;
  localparam logic RELOAD_RST = 1'b1;
  localparam logic [15:0] SEC_ADDR = 16'h4008;
  // Unlock code value is arbitrary.
  localparam logic [15:0] USER_KEY = 16'h9716;
  localparam logic [15:0] WIN_BASE = 16'h5000;
  localparam logic [15:0] WIN_END = 16'h5028;
  // ***********************************************************
  // Serial link
  // ***********************************************************
  localparam logic [7:0] EE_DEV_READ = 8'ha1;
  localparam logic [5:0] EE_BYTES = 6'h30;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [1:0] PH_DRIVE = 2'h0;
  localparam logic [1:0] PH_RISE = 2'h1;
  localparam logic [1:0] PH_SAMPLE = 2'h2;
  localparam logic [1:0] PH_FALL = 2'h3;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_OTP = 3'h1, ST_EE = 3'h3, ST_CHECK = 3'h2,
    ST_PROG = 3'h6
  } bcl_state_t;
  typedef enum logic [1:0] {
    EG_IDLE = 2'h0, EG_START = 2'h1, EG_BIT = 2'h3, EG_STOP = 2'h2
  } bcl_eng_t;
endpackage

// ---- logic/bcl_link_if.sv ----
// Crossing signals between the loader and the serial engine.
`timescale 1ns/100ps
interface bcl_link_if;
  logic start_tgl;
  logic word_tgl;
  logic done_tgl;
  logic nack;
  logic [15:0] word;
  modport ctrl (output start_tgl, input word_tgl, done_tgl, nack, word);
  modport eng (input start_tgl, output word_tgl, done_tgl, nack, word);
endinterface

// ---- logic/bcl_sync.sv ----
// Two flip-flop synchroniser for levels and toggles.
`timescale 1ns/100ps
module bcl_sync #(
  parameter int W = 1
) (
  // Clock
  input wire logic i_clock,
  // Data
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta;
  logic [W-1:0] sync;
  always_ff @(posedge i_clock) begin
    meta <= i_async;
    sync <= meta;
  end
  assign o_sync = sync;
endmodule // bcl_sync

// ---- logic/bcl_ee_reader.sv ----
// Read-only serial master that fetches the external EEPROM image.
`timescale 1ns/100ps
module bcl_ee_reader #(
  parameter int QUARTER = 20
) (
  // Link clock and reset
  input wire logic i_link_clock,
  input wire logic i_link_rst,
  // Crossing to the loader
  bcl_link_if.eng lnk,
  // Pins
  input wire logic i_sda,
  output logic o_scl_oe,
  output logic o_sda_oe
);
  import bcl_pkg::*;
  localparam logic [7:0] QUARTER_M1 = 8'(QUARTER - 1);

  bcl_eng_t st, next_st;
  logic [7:0] div, next_div;
  logic [1:0] ph, next_ph;
  logic [3:0] bitn, next_bitn;
  logic [5:0] nbyte, next_nbyte;
  logic [7:0] sh, next_sh;
  logic [7:0] hi, next_hi;
  logic [15:0] word, next_word;
  logic word_tgl, next_word_tgl, done_tgl, next_done_tgl;
  logic nack, next_nack, seen, next_seen;
  logic scl_oe, next_scl_oe, sda_oe, next_sda_oe;
  logic start_s, sda_s, tick;

  bcl_sync #(.W(2)) u_sync (
    .i_clock(i_link_clock),
    .i_async({lnk.start_tgl, i_sda}),
    .o_sync({start_s, sda_s})
  );

  // ***********************************************************
  // Bit sequencer
  // ***********************************************************
  always_comb begin
    next_st = st; next_ph = ph; next_bitn = bitn; next_nbyte = nbyte;
    next_sh = sh; next_hi = hi; next_word = word;
    next_word_tgl = word_tgl; next_done_tgl = done_tgl;
    next_nack = nack; next_seen = seen;
    next_scl_oe = scl_oe; next_sda_oe = sda_oe;
    tick = (div == QUARTER_M1);
    next_div = tick ? 8'h00 : div + 8'h01;
    if (st == EG_IDLE) begin
      next_div = 8'h00;
      if (start_s != seen) begin
        next_seen = start_s;
        next_nack = 1'b0;
        next_ph = PH_DRIVE;
        next_st = EG_START;
      end
    end else if (tick) begin
      next_ph = ph + 2'h1;
      unique case (st)
        EG_START: begin
          if (ph == PH_DRIVE) next_sda_oe = 1'b1;
          else if (ph == PH_RISE) next_scl_oe = 1'b1;
          else begin
            next_st = EG_BIT;
            next_ph = PH_DRIVE;
            next_bitn = 4'h0;
            next_nbyte = 6'h00;
            next_sh = EE_DEV_READ; // RULE_11
          end
        end
        EG_BIT: begin
          unique case (ph)
            PH_DRIVE: begin
              if (nbyte == 6'h00) // RULE_14
                next_sda_oe = (bitn != ACK_BIT) && !sh[7];
              else
                next_sda_oe = (bitn == ACK_BIT) && (nbyte != EE_BYTES);
            end
            PH_RISE: next_scl_oe = 1'b0;
            PH_SAMPLE: begin
              if (bitn != ACK_BIT) next_sh = {sh[6:0], sda_s};
              else if (nbyte == 6'h00 && sda_s) next_nack = 1'b1; // RULE_19
            end
            PH_FALL: begin
              next_scl_oe = 1'b1;
              next_bitn = bitn + 4'h1;
              if (bitn == ACK_BIT) begin
                next_bitn = 4'h0;
                next_nbyte = nbyte + 6'h01;
                if (nbyte != 6'h00 && nbyte[0]) next_hi = sh; // RULE_12
                if (nbyte != 6'h00 && !nbyte[0]) begin
                  next_word = {hi, sh}; // RULE_12
                  next_word_tgl = !word_tgl;
                end
                if (nack || nbyte == EE_BYTES) next_st = EG_STOP; // RULE_13
              end
            end
          endcase
        end
        EG_STOP: begin
          if (ph == PH_DRIVE) next_sda_oe = 1'b1;
          else if (ph == PH_RISE) next_scl_oe = 1'b0;
          else if (ph == PH_SAMPLE) next_sda_oe = 1'b0;
          else begin
            next_done_tgl = !done_tgl;
            next_st = EG_IDLE;
          end
        end
        default: next_st = EG_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_link_clock) begin
    if (i_link_rst) begin
      st <= EG_IDLE; div <= 8'h00; ph <= PH_DRIVE; bitn <= 4'h0;
      nbyte <= 6'h00; sh <= 8'h00; hi <= 8'h00; word <= 16'h0000;
      word_tgl <= 1'b0; done_tgl <= 1'b0; nack <= 1'b0; seen <= 1'b0;
      scl_oe <= 1'b0; sda_oe <= 1'b0;
    end else begin
      st <= next_st; div <= next_div; ph <= next_ph; bitn <= next_bitn;
      nbyte <= next_nbyte; sh <= next_sh; hi <= next_hi; word <= next_word;
      word_tgl <= next_word_tgl; done_tgl <= next_done_tgl;
      nack <= next_nack; seen <= next_seen;
      scl_oe <= next_scl_oe; sda_oe <= next_sda_oe;
    end
  end

  assign lnk.word = word;
  assign lnk.word_tgl = word_tgl;
  assign lnk.done_tgl = done_tgl;
  assign lnk.nack = nack;
  assign o_scl_oe = scl_oe;
  assign o_sda_oe = sda_oe;

  // The read/write bit of the address byte is always released (read).
  read_only_a: assert property (@(posedge i_link_clock) // RULE_14
    disable iff (i_link_rst)
    (st == EG_BIT && nbyte == 6'h00 && bitn == 4'h7 && ph == PH_DRIVE
     && tick) |=> !sda_oe)
    else $error("address byte does not end in a read bit");
endmodule // bcl_ee_reader

// ---- sim/bcl_ee_model.sv ----
// Behavioural model of the external configuration EEPROM on the serial link.
`timescale 1ns/100ps
module bcl_ee_model (
  // Resolved pin levels
  input wire logic i_scl,
  input wire logic i_sda,
  // Bench control
  input wire logic i_present,
  // Open-drain data pull
  output logic o_sda_oe,
  output logic o_wr_seen
);
  // The bench fills mem only while the loader is idle and off.
  logic [7:0] mem [0:47];
  logic [7:0] sh;
  logic act;
  logic rd;
  int cnt;
  int ptr;
  initial begin
    o_sda_oe = 0;
    o_wr_seen = 0;
    act = 0;
    rd = 0;
    cnt = 0;
    ptr = 0;
  end
  // Pointer restarts at 00h at every start condition, so each load reads from byte 0.
  always @(negedge i_sda) if (i_scl) begin
    act = 1;
    rd = 0;
    cnt = 0;
    ptr = 0;
    o_sda_oe = 0;
  end
  always @(posedge i_sda) if (i_scl) begin
    act = 0;
    o_sda_oe = 0;
  end
  always @(posedge i_scl) if (act) begin
    if (!rd && cnt < 8) sh = {sh[6:0], i_sda};
    if (!rd && cnt == 7 && !sh[0]) o_wr_seen = 1;
    if (rd && cnt == 8 && i_sda) act = 0;
    cnt = (cnt == 8) ? 0 : cnt + 1;
  end
  always @(negedge i_scl) if (act) begin
    if (!rd) begin
      if (cnt == 8) o_sda_oe = i_present && sh == 8'ha1;
      else if (cnt == 0 && o_sda_oe) begin
        rd = 1;
        o_sda_oe = !mem[ptr][7];
      end else o_sda_oe = 0;
    end else if (cnt < 8) o_sda_oe = !mem[ptr][7-cnt];
    else begin
      o_sda_oe = 0;
      ptr++;
    end
  end
endmodule // bcl_ee_model

// ---- sim/bcl_loader_test.sv ----
// Self-checking bench of the bootstrap configuration loader.
`timescale 1ns/100ps
module bcl_loader_test;
  import bcl_pkg::*;
  logic clk = 0, lclk = 0, rst = 1, wr = 0, rd = 0, sched = 0;
  logic prog = 0, cpreq = 0, hold_low = 1, present = 1, rvalid, en = 1;
  logic [15:0] addr = 0, wdata = 0, rdata, otp_q, cp_data;
  logic [15:0] otp [0:31];
  logic [4:0] oaddr;
  logic [5:0] pol;
  logic [1:0] r;
  logic ok, off, dev, orr, owr, soe, doe, eoe, wseen, scl_w, sda_w, busy;
  logic [15:0] owd;
  int n_mismatch = 0, check_count = 0, wr_cnt = 0;
  assign scl_w = !(soe || hold_low);
  assign sda_w = !(doe || eoe);
  initial forever #10 clk = ~clk;
  initial forever #62.5 lclk = ~lclk;
  bcl_loader #(.QUARTER(2)) uut (.i_clock(clk), .i_sys_rst(rst),
    .i_clk_en(en), .i_link_clock(lclk), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .o_reg_rvalid(rvalid), .i_on_sched(sched), .i_program_state(prog),
    .i_otp_copy_req(cpreq), .o_busy(busy), .o_start_ok(ok), .o_stay_off(off),
    .o_dev_mode(dev), .o_otp_addr(oaddr), .o_otp_rd(orr), .o_otp_wr(owr),
    .o_otp_wdata(owd), .i_otp_rdata(otp_q), .i_scl(scl_w), .o_scl(),
    .o_scl_oe(soe), .i_sda(sda_w), .o_sda(), .o_sda_oe(doe),
    .o_gpio_pol_eff(pol));
  bcl_ee_model ee (.i_scl(scl_w), .i_sda(sda_w), .i_present(present),
    .o_sda_oe(eoe), .o_wr_seen(wseen));
  // ***********************************************************
  // One-time memory stand-in and copy monitor
  // ***********************************************************
  // The loader takes OTP data at the edge that ends its read strobe, so
  // data stand only while the strobe does.
  assign otp_q = orr ? otp[oaddr] : 16'h0000;
  always @(negedge clk) begin
    if (owr === 1'b1) begin
      wr_cnt++;
      if (oaddr === 5'h10) cp_data = owd;
    end
  end
  task chk(input string nm, input logic [15:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task wrr(input logic [15:0] a, d);
    @(posedge clk) begin wr <= 1; addr <= a; wdata <= d; end
    @(posedge clk) wr <= 0;
  endtask
  task rchk(input logic [15:0] a, e, input string nm);
    @(posedge clk) begin rd <= 1; addr <= a; end
    @(posedge clk) rd <= 0;
    @(negedge clk);
    chk("rvalid", {15'h0, rvalid}, 16'h1);
    chk(nm, rdata, e);
  endtask
  task set_reload(input logic [15:0] d);
    wrr(SEC_ADDR, USER_KEY);
    wrr(RELOAD_ADDR, d);
  endtask
  // Pulses a schedule and waits for the verdict pulse.
  task run(input logic [15:0] e);
    int n;
    r = 0;
    @(posedge clk) sched <= 1;
    @(posedge clk) sched <= 0;
    @(negedge clk);
    chk("busy", {15'h0, busy}, 16'h1);
    for (n = 0; n < 30000 && r == 0; n++) begin
      @(negedge clk);
      r = {ok, off};
    end
    chk("verdict", {14'h0, r}, e);
    chk("idle", {15'h0, busy}, 16'h0);
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (95000) @(posedge clk);
    n_mismatch++;
    finish_test;
  end
  // ***********************************************************
  // Test sequence
  // ***********************************************************
  initial begin
    for (int i = 0; i < 32; i++) otp[i] = 16'h1000 + i[15:0];
    for (int i = 0; i < 48; i++) ee.mem[i] = i[7:0] + 8'h1;
    ee.mem[32] = 8'ha5;
    ee.mem[33] = 8'h96;
    // Word 24 asks for the on/off function with active-high polarity.
    ee.mem[17] = 8'h02;
    // The first link clock edge falls inside this reset.
    repeat (6) @(posedge clk);
    rst <= 0;
    repeat (20) @(posedge clk);
    rchk(RELOAD_ADDR, 16'h8000, "reload");
    rchk(16'h4100, 16'h0, "unmapped");
    wrr(RELOAD_ADDR, 16'h0);
    rchk(RELOAD_ADDR, 16'h8000, "locked");
    set_reload(16'h0);
    rchk(RELOAD_ADDR, 16'h0, "unlocked");
    wrr(SEC_ADDR, 16'h0);
    wrr(RELOAD_ADDR, 16'h8000);
    rchk(RELOAD_ADDR, 16'h0, "relocked");
    set_reload(16'h8000);
    run(16'h2);
    chk("dev", {15'h0, dev}, 16'h0);
    for (int w = 0; w < 32; w++) rchk(WIN_BASE + w, otp[w], "otp");
    wrr(WIN_BASE, 16'hdead);
    rchk(WIN_BASE, otp[0], "page0");
    wrr(WIN_BASE + 17, 16'h1234);
    rchk(WIN_BASE + 17, 16'h1234, "win");
    en <= 0;
    wrr(WIN_BASE + 17, 16'h5555);
    en <= 1;
    rchk(WIN_BASE + 17, 16'h1234, "frozen");
    set_reload(16'h0);
    otp[0] = 16'h7777;
    run(16'h2);
    rchk(WIN_BASE + 17, 16'h1234, "kept");
    rchk(WIN_BASE, 16'h7777, "refresh");
    wrr(WIN_BASE + 16, 16'h0);
    run(16'h1);
    set_reload(16'h8000);
    otp[16] = 16'h0;
    run(16'h1);
    hold_low = 0;
    repeat (10) @(posedge clk);
    run(16'h2);
    chk("dev", {15'h0, dev}, 16'h1);
    rchk(WIN_BASE + 16, 16'h0102, "pack");
    rchk(WIN_BASE + 39, 16'h2f30, "last");
    rchk(WIN_BASE + 32, 16'ha596, "sig");
    chk("pol", {10'h0, pol}, 16'h3e);
    chk("wr", {15'h0, wseen}, 16'h0);
    ee.mem[33] = 8'h97;
    run(16'h1);
    present = 0;
    run(16'h1);
    hold_low = 1;
    wrr(WIN_BASE + 16, 16'h4242);
    @(posedge clk) cpreq <= 1;
    @(posedge clk) cpreq <= 0;
    repeat (40) @(posedge clk);
    chk("nocopy", wr_cnt[15:0], 16'h0);
    prog <= 1;
    @(posedge clk) cpreq <= 1;
    @(posedge clk) cpreq <= 0;
    repeat (40) @(posedge clk);
    chk("copies", wr_cnt[15:0], 16'h10);
    chk("copy", cp_data, 16'h4242);
    finish_test;
  end
endmodule // bcl_loader_test
